// ==== logic/cansfi_consts.svh ====
// Offsets, field positions, reset values and codes of the CAN status and interrupt registers.
`ifndef CANSFI_CONSTS_SVH
`define CANSFI_CONSTS_SVH

// Register byte offsets.
`define CANSFI_OFS_FILTER_COUNT 12'h000
`define CANSFI_OFS_INT_CODE     12'h004
`define CANSFI_OFS_FIFO_CTRL    12'h008
`define CANSFI_OFS_FIFO_STAT    12'h00c
`define CANSFI_OFS_INT_FLAGS    12'h010
`define CANSFI_OFS_INT_ENABLE   12'h014

// Field positions.
`define CANSFI_POS_HIT        8
`define CANSFI_POS_AREA_SIZE  13
`define CANSFI_POS_WR_PTR     8
`define CANSFI_POS_ERR_STAT   8

// Interrupt flag bit positions.
`define CANSFI_BIT_INVALID  7
`define CANSFI_BIT_WAKE     6
`define CANSFI_BIT_ERROR    5
`define CANSFI_BIT_FIFO     3
`define CANSFI_BIT_OVERFLOW 2
`define CANSFI_BIT_RX_BUF   1
`define CANSFI_BIT_TX_BUF   0
`define CANSFI_FLAG_MASK    8'hef

// Limits and reset values.
`define CANSFI_COMPARE_MAX  5'h11
`define CANSFI_FILTER_MAX   5'h0f
`define CANSFI_SIZE_RSVD    3'h7
`define CANSFI_RST_FLAGS    8'h00
`define CANSFI_RST_ENABLE   8'h00

// Interrupt source codes.
`define CANSFI_CODE_NONE     7'h40
`define CANSFI_CODE_ERROR    7'h41
`define CANSFI_CODE_WAKE     7'h42
`define CANSFI_CODE_OVERFLOW 7'h43
`define CANSFI_CODE_FIFO     7'h44

`endif

// ==== logic/cansfi_pkg.sv ====
// Types shared by the CAN status and interrupt register block.
package cansfi_pkg;

   // Error state levels reported by the protocol engine.
   typedef struct packed {
      logic tx_bus_off;
      logic tx_error_passive;
      logic rx_error_passive;
      logic tx_error_warning;
      logic rx_error_warning;
   } cansfi_err_s;

   // One-cycle event pulses from the receive and transmit logic.
   typedef struct packed {
      logic       invalid_message;
      logic       bus_activity;
      logic       fifo_almost_full;
      logic       rx_overflow;
      logic       rx_buffer_done;
      logic       tx_buffer_done;
      logic [3:0] buffer_number;
      logic [4:0] matched_filter_number;
   } cansfi_evt_s;

   // APB slave handshake states.
   typedef enum logic [0:0] {
      CANSFI_IDLE = 1'b0,
      CANSFI_DONE = 1'b1
   } cansfi_bus_e;

endpackage

// ==== logic/cansfi_regs.sv ====
// CAN status, FIFO and interrupt register block with an APB slave port.
`timescale 1ns/1ps
`include "cansfi_consts.svh"

module cansfi_regs #(
   parameter int ADDR_W = 12
) (
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic [4:0]           i_data_bit_compare_count,
   input  wire cansfi_pkg::cansfi_err_s i_err,
   input  wire cansfi_pkg::cansfi_evt_s i_evt,
   input  wire logic                 i_disable_mode,
   input  wire logic [5:0]           i_fifo_write_pointer,
   input  wire logic [5:0]           i_fifo_next_read_pointer,
   output logic [2:0]                o_buffer_area_size,
   output logic [4:0]                o_fifo_first_buffer,
   output logic [4:0]                o_data_bit_compare_count,
   output logic                      o_irq
);

   // ***************************************************************
   // Reset release
   // ***************************************************************

   logic rst_meta_n;
   logic rst_n;

   // The reset is released through two flops so all state leaves reset on one edge.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************

   // Picks the byte lanes of a write that are strobed.
   function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
      logic [15:0] r;
      r = old_v;
      if (st[0]) begin
         r[7:0] = wd[7:0];
      end
      if (st[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // Error flag cause: any status bit that was clear and is now set.
   function automatic logic rises(input logic [5:0] now_v,
                                  input logic [5:0] old_v);
      return |(now_v & ~old_v);
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************

   logic [7:0] flags;
   logic [7:0] next_flags;
   logic [7:0] enable;
   logic [7:0] next_enable;
   logic [5:0] err_stat;
   logic [5:0] next_err_stat;
   logic [3:0] last_buf;
   logic [3:0] next_last_buf;
   logic [4:0] hit;
   logic [4:0] next_hit;
   logic [2:0] area_size;
   logic [2:0] next_area_size;
   logic [4:0] first_buf;
   logic [4:0] next_first_buf;
   logic [4:0] cmp_count;
   logic [4:0] next_cmp_count;
   logic [5:0] wr_ptr;
   logic [5:0] next_wr_ptr;
   logic [5:0] rd_ptr;
   logic [5:0] next_rd_ptr;
   logic [6:0] code;
   logic [6:0] next_code;
   logic       irq;
   logic       next_irq;

   cansfi_pkg::cansfi_bus_e bus_st;
   cansfi_pkg::cansfi_bus_e next_bus_st;
   logic        next_pready;
   logic [31:0] next_prdata;
   logic        next_pslverr;

   logic        access;
   logic        commit_wr;
   logic        hit_map;
   logic [15:0] wr_word;
   logic [15:0] rd_word;
   logic [7:0]  pending;
   logic [5:0]  err_now;

   // ***************************************************************
   // Bus decode
   // ***************************************************************

   // A write takes effect only at the edge where pready is seen high.
   assign access    = psel && penable;
   assign commit_wr = access && pready && pwrite && hit_map;

   // Register read mux; unimplemented bits are zero here and nowhere stored.
   always_comb begin
      hit_map = 1'b1;
      rd_word = 16'h0000;
      case (paddr)
         `CANSFI_OFS_FILTER_COUNT: begin
            rd_word = {11'h000, cmp_count};
         end
         `CANSFI_OFS_INT_CODE: begin
            rd_word = {3'h0, hit, 1'b0, code};
         end
         `CANSFI_OFS_FIFO_CTRL: begin
            rd_word = {area_size, 8'h00, first_buf};
         end
         `CANSFI_OFS_FIFO_STAT: begin
            rd_word = {2'h0, wr_ptr, 2'h0, rd_ptr};
         end
         `CANSFI_OFS_INT_FLAGS: begin
            rd_word = {2'h0, err_stat, flags};
         end
         `CANSFI_OFS_INT_ENABLE: begin
            rd_word = {8'h00, enable};
         end
         default: begin
            hit_map = 1'b0;
         end
      endcase
   end

   assign wr_word = lane_merge(16'h0000, pwdata, pstrb);

   // ***************************************************************
   // APB handshake
   // ***************************************************************

   // One wait state: read data is built in the first access cycle.
   always_comb begin
      next_bus_st  = bus_st;
      next_pready  = 1'b0;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      case (bus_st)
         cansfi_pkg::CANSFI_IDLE: begin
            if (access) begin
               next_bus_st  = cansfi_pkg::CANSFI_DONE;
               next_pready  = 1'b1;
               next_pslverr = !hit_map;
               next_prdata  = (pwrite || !hit_map) ? 32'h0000_0000 : {16'h0000, rd_word};
            end
         end
         cansfi_pkg::CANSFI_DONE: begin
            next_bus_st = cansfi_pkg::CANSFI_IDLE;
         end
         default: begin
            next_bus_st = cansfi_pkg::CANSFI_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_st  <= cansfi_pkg::CANSFI_IDLE;
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         bus_st  <= next_bus_st;
         pready  <= next_pready;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ***************************************************************
   // Software-written control
   // ***************************************************************

   // A reserved area size code is refused so the buffer map stays defined.
   always_comb begin
      next_area_size = area_size;
      next_first_buf = first_buf;
      next_enable    = enable;
      if (commit_wr && paddr == `CANSFI_OFS_FIFO_CTRL) begin
         if (pstrb[1] && wr_word[15:13] != `CANSFI_SIZE_RSVD) begin
            next_area_size = wr_word[15:13];
         end
         if (pstrb[0]) begin
            next_first_buf = wr_word[4:0];
         end
      end
      if (commit_wr && paddr == `CANSFI_OFS_INT_ENABLE && pstrb[0]) begin
         next_enable = wr_word[7:0] & `CANSFI_FLAG_MASK;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         area_size <= 3'h0;
         first_buf <= 5'h00;
         enable    <= `CANSFI_RST_ENABLE;
      end else begin
         area_size <= next_area_size;
         first_buf <= next_first_buf;
         enable    <= next_enable;
      end
   end

   // ***************************************************************
   // Status capture
   // ***************************************************************

   assign err_now = {i_err.tx_bus_off,
                     i_err.tx_error_passive,
                     i_err.rx_error_passive,
                     i_err.tx_error_warning,
                     i_err.rx_error_warning,
                     i_err.tx_error_warning | i_err.rx_error_warning};

   // Status follows the engine one cycle late; out-of-range codes are held off.
   always_comb begin
      next_err_stat = err_now;
      next_wr_ptr   = i_fifo_write_pointer;
      next_rd_ptr   = i_fifo_next_read_pointer;
      next_cmp_count = cmp_count;
      if (i_data_bit_compare_count <= `CANSFI_COMPARE_MAX) begin
         next_cmp_count = i_data_bit_compare_count;
      end
      next_hit      = hit;
      next_last_buf = last_buf;
      if (i_evt.rx_buffer_done && i_evt.matched_filter_number <= `CANSFI_FILTER_MAX) begin
         next_hit = i_evt.matched_filter_number;
      end
      if (i_evt.rx_buffer_done || i_evt.tx_buffer_done) begin
         next_last_buf = i_evt.buffer_number;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_stat  <= 6'h00;
         wr_ptr    <= 6'h00;
         rd_ptr    <= 6'h00;
         cmp_count <= 5'h00;
         hit       <= 5'h00;
         last_buf  <= 4'h0;
      end else begin
         err_stat  <= next_err_stat;
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         cmp_count <= next_cmp_count;
         hit       <= next_hit;
         last_buf  <= next_last_buf;
      end
   end

   // ***************************************************************
   // Interrupt flags
   // ***************************************************************

   // Writing zero clears, writing one keeps; a new event in the same cycle wins.
   always_comb begin
      next_flags = flags;
      if (commit_wr && paddr == `CANSFI_OFS_INT_FLAGS && pstrb[0]) begin
         next_flags = flags & wr_word[7:0];
      end
      if (i_evt.invalid_message) begin
         next_flags[`CANSFI_BIT_INVALID] = 1'b1;
      end
      if (i_evt.bus_activity) begin
         next_flags[`CANSFI_BIT_WAKE] = 1'b1;
      end
      if (rises(err_now, err_stat)) begin
         next_flags[`CANSFI_BIT_ERROR] = 1'b1;
      end
      if (i_evt.fifo_almost_full) begin
         next_flags[`CANSFI_BIT_FIFO] = 1'b1;
      end
      if (i_evt.rx_overflow) begin
         next_flags[`CANSFI_BIT_OVERFLOW] = 1'b1;
      end
      if (i_evt.rx_buffer_done) begin
         next_flags[`CANSFI_BIT_RX_BUF] = 1'b1;
      end
      if (i_evt.tx_buffer_done) begin
         next_flags[`CANSFI_BIT_TX_BUF] = 1'b1;
      end
      next_flags = next_flags & `CANSFI_FLAG_MASK;
   end

   // The disable mode input deliberately gates nothing: flags are kept in every mode.
   assign pending = flags & enable;

   // Fixed priority: error, wake, overflow, FIFO, then buffer events.
   always_comb begin
      next_code = `CANSFI_CODE_NONE;
      if (pending[`CANSFI_BIT_ERROR]) begin
         next_code = `CANSFI_CODE_ERROR;
      end else if (pending[`CANSFI_BIT_WAKE]) begin
         next_code = `CANSFI_CODE_WAKE;
      end else if (pending[`CANSFI_BIT_OVERFLOW]) begin
         next_code = `CANSFI_CODE_OVERFLOW;
      end else if (pending[`CANSFI_BIT_FIFO]) begin
         next_code = `CANSFI_CODE_FIFO;
      end else if (pending[`CANSFI_BIT_RX_BUF] || pending[`CANSFI_BIT_TX_BUF]) begin
         next_code = {3'h0, last_buf};
      end
      next_irq = |pending;
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= `CANSFI_RST_FLAGS;
         code  <= `CANSFI_CODE_NONE;
         irq   <= 1'b0;
      end else begin
         flags <= next_flags;
         code  <= next_code;
         irq   <= next_irq;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************

   // All outputs come straight from flops.
   assign o_buffer_area_size       = area_size;
   assign o_fifo_first_buffer      = first_buf;
   assign o_data_bit_compare_count = cmp_count;
   assign o_irq                    = irq;

endmodule

// ==== sim/cansfi_engine_model.sv ====
// Behavioural protocol engine feeding events, error levels and FIFO pointers.
`timescale 1ns/1ps
module cansfi_engine_model (
   input  wire logic              i_core_clk,
   output cansfi_pkg::cansfi_evt_s o_evt,
   output cansfi_pkg::cansfi_err_s o_err,
   output logic [5:0]              o_wr_ptr,
   output logic [5:0]              o_rd_ptr
);
   // ****************************************
   // Engine outputs
   // ****************************************

   // Quiet at time zero: no pulse, no error state, both pointers at buffer 0.
   initial begin
      o_evt = '0;
      o_err = '0;
      o_wr_ptr = 6'h00;
      o_rd_ptr = 6'h00;
   end

   // One-cycle pulse; number fields then turn to their inverse, as they mean nothing without a pulse.
   task automatic pulse(input logic [5:0] kinds, input logic [3:0] num, input logic [4:0] hit);
      @(posedge i_core_clk);
      o_evt <= {kinds, num, hit};
      @(posedge i_core_clk);
      o_evt <= {6'h00, ~num, ~hit};
   endtask

   // Error levels and pointers change just after an edge and then hold.
   task automatic set_err(input cansfi_pkg::cansfi_err_s e);
      @(posedge i_core_clk);
      o_err <= e;
   endtask
   task automatic set_ptr(input logic [5:0] w, input logic [5:0] r);
      @(posedge i_core_clk);
      o_wr_ptr <= w;
      o_rd_ptr <= r;
   endtask
endmodule

// ==== sim/cansfi_regs_properties.sv ====
// Concurrent checks on the ports of the CAN status and interrupt register block.
`timescale 1ns/1ps
module cansfi_regs_properties #(
   parameter int ADDR_W = 12
) (
   input wire logic                    i_core_clk,
   input wire logic                    i_rst_n,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [ADDR_W-1:0]       paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [3:0]              pstrb,
   input wire logic                    pready,
   input wire logic [31:0]             prdata,
   input wire logic                    pslverr,
   input wire logic [4:0]              i_data_bit_compare_count,
   input wire cansfi_pkg::cansfi_err_s i_err,
   input wire cansfi_pkg::cansfi_evt_s i_evt,
   input wire logic [2:0]              o_buffer_area_size,
   input wire logic [4:0]              o_fifo_first_buffer,
   input wire logic [4:0]              o_data_bit_compare_count,
   input wire logic                    o_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   logic [1:0]              up_cnt;
   logic [3:0]              cause_h;
   logic [3:0]              wr_h;
   cansfi_pkg::cansfi_err_s err_q;
   logic                    up_ok;
   logic                    wr_done;
   logic                    ctl_wr;

   // ****************************************
   // Helper logic
   // ****************************************

   // The design resets through two flops, so its outputs follow inputs only from the third edge on.
   assign up_ok = (up_cnt == 2'd3);
   assign wr_done = pready && pwrite;
   assign ctl_wr = wr_done && !pslverr && paddr == 12'h008 && pstrb == 4'hf && pwdata[15:13] != 3'h7;

   // Short histories of writes and of anything that may raise the interrupt line.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         up_cnt <= 2'd0;
         err_q <= '0;
         wr_h <= 4'h0;
         cause_h <= 4'h0;
      end else begin
         up_cnt <= up_ok ? up_cnt : up_cnt + 2'd1;
         err_q <= i_err;
         wr_h <= {wr_h[2:0], wr_done};
         cause_h <= {cause_h[2:0], wr_done || (|i_evt[14:9]) || ((i_err & ~err_q) != '0)};
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   AST_READY_NEXT: assert property (psel && penable && !pready |=> pready)
      else $error("Access not answered after one wait state.");
   AST_READY_ONE: assert property (pready |=> !pready)
      else $error("Ready stayed high.");
   AST_SLVERR_MAP: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008,
      12'h00c, 12'h010, 12'h014})) else $error("Error response does not match the address.");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("Upper read half not zero.");
   AST_CMP_PASS: assert property (up_ok && i_data_bit_compare_count <= 5'h11 |=>
      o_data_bit_compare_count == $past(i_data_bit_compare_count)) else $error("Valid count not taken.");
   AST_CMP_HOLD: assert property (up_ok && i_data_bit_compare_count > 5'h11 |=>
      $stable(o_data_bit_compare_count)) else $error("Invalid count taken.");
   AST_AREA_WR: assert property (ctl_wr |=> o_buffer_area_size == $past(pwdata[15:13]))
      else $error("Area size not written.");
   AST_FIRST_WR: assert property (ctl_wr |=> o_fifo_first_buffer == $past(pwdata[4:0]))
      else $error("First FIFO buffer not written.");
   AST_AREA_RSVD: assert property (o_buffer_area_size != 3'h7)
      else $error("Reserved area size shown.");
   AST_IRQ_RISE: assert property ($rose(o_irq) |-> |cause_h)
      else $error("Interrupt rose without a cause.");
   AST_IRQ_FALL: assert property ($fell(o_irq) |-> |wr_h)
      else $error("Interrupt fell without a write.");

   // Main scenarios reached.
   cover property (pready && pslverr);
   cover property ($rose(o_irq));
   cover property (wr_done && paddr == 12'h008 && pwdata[15:13] == 3'h7);
endmodule

// ==== sim/test_can_status_fifo_interrupt_regs.sv ====
// Self-checking bench for the CAN status, FIFO and interrupt register block.
`timescale 1ns/1ps
module test_can_status_fifo_interrupt_regs;
   logic                    i_core_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, i_disable_mode, o_irq;
   logic [11:0]             paddr;
   logic [31:0]             pwdata, prdata;
   logic [3:0]              pstrb;
   logic [4:0]              i_data_bit_compare_count, o_data_bit_compare_count, o_fifo_first_buffer;
   logic [2:0]              o_buffer_area_size;
   logic [5:0]              i_fifo_write_pointer, i_fifo_next_read_pointer;
   cansfi_pkg::cansfi_err_s i_err;
   cansfi_pkg::cansfi_evt_s i_evt;
   int                      err_count = 0, n_tests = 0, cyc = 0;

   cansfi_regs #(.ADDR_W(12)) cansfi_regs_inst (.*);
   cansfi_engine_model cansfi_engine_model_inst (.i_core_clk(i_core_clk), .o_evt(i_evt), .o_err(i_err),
      .o_wr_ptr(i_fifo_write_pointer), .o_rd_ptr(i_fifo_next_read_pointer));

   // ****************************************
   // Clock, watchdog and bus tasks
   // ****************************************

   // Free-running 50 MHz clock.
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end

   // The run needs a few hundred cycles, so this ceiling only trips on a hang.
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request holds until ready is seen high, and only the watchdog ends a hang.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      @(posedge i_core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_core_clk);
      penable <= 1'b1;
      @(posedge i_core_clk);
      while (pready !== 1'b1) begin
         @(posedge i_core_clk);
      end
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic        e;
      apb(1'b0, a, 32'h0, v, e);
      chk(v, exp);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic        e;
      apb(1'b1, a, d, v, e);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_and_map();
      logic [31:0] v;
      logic        e;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h40);
      rd(12'h008, 32'h0);
      rd(12'h010, 32'h0);
      rd(12'h014, 32'h0);
      apb(1'b0, 12'h018, 32'h0, v, e);
      chk({v[31:1], e}, 32'h1);
      wr(12'h004, 32'hffff_ffff);
      rd(12'h004, 32'h40);
   endtask

   task automatic t_compare();
      i_data_bit_compare_count <= 5'h11;
      rd(12'h000, 32'h11);
      i_data_bit_compare_count <= 5'h12;
      rd(12'h000, 32'h11);
      chk({27'h0, o_data_bit_compare_count}, 32'h11);
      i_data_bit_compare_count <= 5'h00;
      rd(12'h000, 32'h0);
   endtask

   // Every area size code, with the unused middle bits set; then the reserved code.
   task automatic t_fifo_ctrl();
      for (int c = 0; c < 7; c++) begin
         wr(12'h008, {16'hffff, 3'(c), 8'hff, 5'h1f});
         rd(12'h008, {16'h0, 3'(c), 8'h0, 5'h1f});
      end
      wr(12'h008, 32'h0000_e000);
      // Look one edge after the write lands, so a wrongly taken code would already show.
      @(posedge i_core_clk);
      chk({29'h0, o_buffer_area_size}, 32'h6);
      chk({27'h0, o_fifo_first_buffer}, 32'h0);
      cansfi_engine_model_inst.set_ptr(6'h1f, 6'h1e);
      rd(12'h00c, 32'h1f1e);
   endtask

   task automatic t_errors();
      wr(12'h014, 32'h20);
      cansfi_engine_model_inst.set_err(5'b00010);
      rd(12'h010, 32'h0520);
      rd(12'h004, 32'h41);
      cansfi_engine_model_inst.set_err(5'b11101);
      rd(12'h010, 32'h3b20);
      wr(12'h010, 32'h0);
      rd(12'h010, 32'h3b00);
      cansfi_engine_model_inst.set_err(5'b00000);
      rd(12'h010, 32'h0);
   endtask

   // Each pulsed source alone, all enabled: flag, code, interrupt, then clearing.
   task automatic t_events();
      logic [5:0]  kinds [6] = '{6'h01, 6'h02, 6'h10, 6'h04, 6'h08, 6'h20};
      logic [15:0] flag  [6] = '{16'h01, 16'h02, 16'h40, 16'h04, 16'h08, 16'h80};
      logic [15:0] code  [6] = '{16'h0007, 16'h0309, 16'h0342, 16'h0343, 16'h0344, 16'h0340};
      wr(12'h014, 32'hef);
      for (int i = 0; i < 6; i++) begin
         cansfi_engine_model_inst.pulse(kinds[i], (i == 0) ? 4'h7 : 4'h9, 5'h03);
         rd(12'h010, {16'h0, flag[i]});
         rd(12'h004, {16'h0, code[i]});
         chk({31'h0, o_irq}, 32'h1);
         wr(12'h010, 32'hffff);
         rd(12'h010, {16'h0, flag[i]});
         wr(12'h010, 32'h0);
         rd(12'h010, 32'h0);
         chk({31'h0, o_irq}, 32'h0);
      end
   endtask

   // Priority, masking, disable mode and a reserved filter number.
   task automatic t_mixed();
      cansfi_engine_model_inst.pulse(6'h14, 4'h0, 5'h00);
      rd(12'h004, 32'h0342);
      wr(12'h010, 32'h0);
      wr(12'h014, 32'h0);
      i_disable_mode <= 1'b1;
      cansfi_engine_model_inst.pulse(6'h10, 4'h0, 5'h00);
      rd(12'h010, 32'h40);
      rd(12'h004, 32'h0340);
      chk({31'h0, o_irq}, 32'h0);
      wr(12'h014, 32'h40);
      rd(12'h004, 32'h0342);
      chk({31'h0, o_irq}, 32'h1);
      wr(12'h010, 32'h0);
      i_disable_mode <= 1'b0;
      wr(12'h014, 32'h02);
      cansfi_engine_model_inst.pulse(6'h02, 4'h2, 5'h14);
      rd(12'h004, 32'h0302);
      wr(12'h010, 32'h0);
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Reset for 20 cycles, let the two-flop release settle, then run every scenario.
   initial begin
      i_rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      i_data_bit_compare_count = 5'h00;
      i_disable_mode = 1'b0;
      repeat (20) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      t_reset_and_map();
      t_compare();
      t_fifo_ctrl();
      t_errors();
      t_events();
      t_mixed();
      finish_test();
   end
endmodule

bind cansfi_regs cansfi_regs_properties #(.ADDR_W(ADDR_W)) cansfi_regs_properties_inst (.*);
